// ---- pkg/ecio_defs.svh ----
// constants for the event contact i/o settings block; definitions only.
// assumes one 16-bit holding register port on the core clock.
`ifndef ECIO_DEFS_SVH
`define ECIO_DEFS_SVH

// register indices
`define ECIO_IDX_TYPE0 5'h00
`define ECIO_IDX_CHAN0 5'h04
`define ECIO_IDX_INV0 5'h08
`define ECIO_IDX_COMBINE 5'h0c
`define ECIO_IDX_DELAY 5'h0d
`define ECIO_IDX_CONTACT_MON 5'h0e
`define ECIO_IDX_LOGIC_MON 5'h0f
`define ECIO_IDX_OUT_STATE 5'h10
`define ECIO_IDX_MANUAL 5'h11
`define ECIO_IDX_SETPOINT 5'h12
`define ECIO_IDX_OUT_FUNC 5'h13
`define ECIO_IDX_OUT_CHAN 5'h14
`define ECIO_IDX_OUT_MODE 5'h15
`define ECIO_IDX_HYST 5'h16
`define ECIO_IDX_LATCH 5'h17
`define ECIO_IDX_ALM_DELAY 5'h18

// value limits
`define ECIO_TYPE_MAX 16'h0010
`define ECIO_CHAN_MIN 16'h0001
`define ECIO_CHAN_MAX 16'h0050
`define ECIO_LOCAL_CHANS 7'h08
`define ECIO_BIT_MAX 16'h0001
`define ECIO_COMBINE_MAX 16'h0003
`define ECIO_BYTE_MAX 16'h00ff
`define ECIO_OUT_FUNC_MAX 16'h001e
`define ECIO_OUT_CHAN_MAX 16'h0028
`define ECIO_OUT_MODE_MAX 16'h0028
`define ECIO_HYST_MAX 16'h03e8

// reset values
`define ECIO_RST_ZERO 16'h0000
`define ECIO_RST_CHAN 16'h0001
`define ECIO_RST_DELAY 8'h01
`define ECIO_RST_HYST 16'h000a

`endif

// ---- pkg/ecio_pkg.sv ----
// types for the event contact i/o settings block.
// assumes ecio_defs.svh supplies the numeric constants.
package ecio_pkg;
  // combine function codes
  typedef enum logic [1:0] {
    COMB_AND = 2'b00,
    COMB_NAND = 2'b01,
    COMB_OR = 2'b10,
    COMB_NOR = 2'b11
  } ecio_comb_e;
  typedef logic [15:0] ecio_word_t;
endpackage

// ---- rtl/ecio_top.sv ----
// event contact input and event output settings bank with logic section.
// assumes a host on the same clock drives the holding register port and
// the event output function and channel events come from same-clock logic.
`timescale 1ns/100ps
`include "ecio_defs.svh"

module ecio_top #(
  parameter int NUM_CONTACTS = 8,
  parameter int NUM_EXT = 72
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // holding register port
  input wire logic [4:0] regAddr,
  input wire logic regWrEn,
  input wire logic [15:0] regWrData,
  output logic [15:0] regRdData,
  output logic regWrReject,
  // contact pins and other channel events
  input wire logic [NUM_CONTACTS-1:0] contactPin,
  input wire logic [NUM_EXT-1:0] extEvent,
  // event output function request and alarm range limits
  input wire logic [7:0] eventOutReq,
  input wire logic signed [15:0] alarmLimLo,
  input wire logic signed [15:0] alarmLimHi,
  // results
  output logic logicResult,
  output logic [7:0] outDrive,
  output logic [15:0] alarmSetpoint,
  output logic [4:0] outFunction,
  output logic [5:0] outChannel,
  output logic [5:0] outMode,
  output logic [9:0] alarmHyst,
  output logic alarmLatch,
  output logic [7:0] alarmDelay
);

  // settings storage
  logic [4:0] inType_r [4];
  logic [6:0] inChan_r [4];
  logic [3:0] inInvert_r;
  ecio_pkg::ecio_comb_e combine_r;
  logic [7:0] inDelay_r;
  logic [7:0] manual_r;
  logic [15:0] setpoint_r;
  logic [4:0] outFunc_r;
  logic [5:0] outChan_r;
  logic [5:0] outMode_r;
  logic [9:0] hyst_r;
  logic latch_r;
  logic [7:0] almDelay_r;
  logic [7:0] outDrive_r;
  logic [15:0] rdData_r;
  logic wrReject_r;
  logic result_r;
  logic [7:0] stableCnt_r;
  logic [NUM_CONTACTS-1:0] sync1_r, sync2_r, sync3_r, contact_r;
  logic [3:0] logicIn;
  logic rawResult;
  logic wrOk;

  // range check shared by every writable setting except the setpoint, which is checked signed against the alarm limits
  function automatic logic inRange(input logic [15:0] v, input logic [15:0] lo,
                                   input logic [15:0] hi);
    inRange = (v >= lo) && (v <= hi);
  endfunction

  // pick one channel state: local contacts first, then the other channels
  function automatic logic chanState(input logic [6:0] ch,
                                     input logic [NUM_CONTACTS-1:0] loc,
                                     input logic [NUM_EXT-1:0] ext);
    logic [6:0] idx;
    idx = ch - 7'h01;
    if (ch <= `ECIO_LOCAL_CHANS) begin
      chanState = loc[idx[2:0]];
    end else begin
      chanState = ext[idx - `ECIO_LOCAL_CHANS];
    end
  endfunction

  // write validation; reserved or read-only indices refuse every write
  always_comb begin
    unique case (regAddr)
      `ECIO_IDX_TYPE0, 5'h01, 5'h02, 5'h03: wrOk = inRange(regWrData, `ECIO_RST_ZERO,
                                                            `ECIO_TYPE_MAX);
      `ECIO_IDX_CHAN0, 5'h05, 5'h06, 5'h07: wrOk = inRange(regWrData, `ECIO_CHAN_MIN,
                                                            `ECIO_CHAN_MAX);
      `ECIO_IDX_INV0, 5'h09, 5'h0a, 5'h0b, `ECIO_IDX_LATCH: wrOk = inRange(regWrData,
                                                       `ECIO_RST_ZERO, `ECIO_BIT_MAX);
      `ECIO_IDX_COMBINE: wrOk = inRange(regWrData, `ECIO_RST_ZERO, `ECIO_COMBINE_MAX);
      `ECIO_IDX_DELAY, `ECIO_IDX_MANUAL, `ECIO_IDX_ALM_DELAY: wrOk = inRange(regWrData,
                                                       `ECIO_RST_ZERO, `ECIO_BYTE_MAX);
      `ECIO_IDX_SETPOINT: wrOk = ($signed(regWrData) >= alarmLimLo)
                                 && ($signed(regWrData) <= alarmLimHi);
      `ECIO_IDX_OUT_FUNC: wrOk = inRange(regWrData, `ECIO_RST_ZERO, `ECIO_OUT_FUNC_MAX);
      `ECIO_IDX_OUT_CHAN: wrOk = inRange(regWrData, `ECIO_CHAN_MIN, `ECIO_OUT_CHAN_MAX);
      `ECIO_IDX_OUT_MODE: wrOk = inRange(regWrData, `ECIO_RST_ZERO, `ECIO_OUT_MODE_MAX);
      `ECIO_IDX_HYST: wrOk = inRange(regWrData, `ECIO_RST_ZERO, `ECIO_HYST_MAX);
      default: wrOk = 1'b0;
    endcase
  end

  // input side settings
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 4; i++) begin
        inType_r[i] <= 5'h00;
        inChan_r[i] <= 7'h01;
      end
      inInvert_r <= 4'h0;
      combine_r <= ecio_pkg::COMB_AND;
      inDelay_r <= `ECIO_RST_DELAY;
    end else if (regWrEn && wrOk) begin
      for (int i = 0; i < 4; i++) begin
        if (regAddr == `ECIO_IDX_TYPE0 + 5'(i)) inType_r[i] <= regWrData[4:0];
        if (regAddr == `ECIO_IDX_CHAN0 + 5'(i)) inChan_r[i] <= regWrData[6:0];
        if (regAddr == `ECIO_IDX_INV0 + 5'(i)) inInvert_r[i] <= regWrData[0];
      end
      if (regAddr == `ECIO_IDX_COMBINE) combine_r <= ecio_pkg::ecio_comb_e'(regWrData[1:0]);
      if (regAddr == `ECIO_IDX_DELAY) inDelay_r <= regWrData[7:0];
    end
  end

  // output side settings
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      manual_r <= 8'h00;
      setpoint_r <= `ECIO_RST_ZERO;
      outFunc_r <= 5'h00;
      outChan_r <= 6'h01;
      outMode_r <= 6'h00;
      hyst_r <= 10'(`ECIO_RST_HYST);
      latch_r <= 1'b0;
      almDelay_r <= 8'h00;
    end else if (regWrEn && wrOk) begin
      unique case (regAddr)
        `ECIO_IDX_MANUAL: manual_r <= regWrData[7:0];
        `ECIO_IDX_SETPOINT: setpoint_r <= regWrData;
        `ECIO_IDX_OUT_FUNC: outFunc_r <= regWrData[4:0];
        `ECIO_IDX_OUT_CHAN: outChan_r <= regWrData[5:0];
        `ECIO_IDX_OUT_MODE: outMode_r <= regWrData[5:0];
        `ECIO_IDX_HYST: hyst_r <= regWrData[9:0];
        `ECIO_IDX_LATCH: latch_r <= regWrData[0];
        `ECIO_IDX_ALM_DELAY: almDelay_r <= regWrData[7:0];
        default: ;
      endcase
    end
  end

  // refused write flag, one cycle per refused write
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) wrReject_r <= 1'b0;
    else wrReject_r <= regWrEn && !wrOk;
  end

  // contact pins: three stages, a bit changes once stages two and three agree
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      contact_r <= '0;
    end else begin
      sync1_r <= contactPin;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      for (int i = 0; i < NUM_CONTACTS; i++) begin
        if (sync2_r[i] == sync3_r[i]) contact_r[i] <= sync3_r[i];
      end
    end
  end

  // logic inputs; type 0 leaves an input unused and reading off
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      logicIn[i] = (inType_r[i] != 5'h00)
                   && (chanState(inChan_r[i], contact_r, extEvent) ^ inInvert_r[i]);
    end
  end

  always_comb begin
    unique case (combine_r)
      ecio_pkg::COMB_AND: rawResult = &logicIn;
      ecio_pkg::COMB_NAND: rawResult = ~&logicIn;
      ecio_pkg::COMB_OR: rawResult = |logicIn;
      ecio_pkg::COMB_NOR: rawResult = ~|logicIn;
    endcase
  end

  // delay count applied
  // one sample per clock; a glitch back to the held value restarts the count
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      result_r <= 1'b0;
      stableCnt_r <= 8'h00;
    end else if (rawResult == result_r) begin
      stableCnt_r <= 8'h00;
    end else if (inDelay_r == 8'h00 || stableCnt_r + 8'h01 >= inDelay_r) begin
      result_r <= rawResult;
      stableCnt_r <= 8'h00;
    end else begin
      stableCnt_r <= stableCnt_r + 8'h01;
    end
  end

  // output drive: manual bits or the event output function
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) outDrive_r <= 8'h00;
    else outDrive_r <= manual_r | eventOutReq;
  end

  // read mux, registered; unmapped indices read zero
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdData_r <= `ECIO_RST_ZERO;
    end else begin
      rdData_r <= `ECIO_RST_ZERO;
      for (int i = 0; i < 4; i++) begin
        if (regAddr == `ECIO_IDX_TYPE0 + 5'(i)) rdData_r <= 16'(inType_r[i]);
        if (regAddr == `ECIO_IDX_CHAN0 + 5'(i)) rdData_r <= 16'(inChan_r[i]);
        if (regAddr == `ECIO_IDX_INV0 + 5'(i)) rdData_r <= 16'(inInvert_r[i]);
      end
      unique case (regAddr)
        `ECIO_IDX_COMBINE: rdData_r <= 16'(combine_r);
        `ECIO_IDX_DELAY: rdData_r <= 16'(inDelay_r);
        `ECIO_IDX_CONTACT_MON: rdData_r <= 16'(contact_r);
        `ECIO_IDX_LOGIC_MON: rdData_r <= 16'({result_r, logicIn});
        `ECIO_IDX_OUT_STATE: rdData_r <= 16'(outDrive_r);
        `ECIO_IDX_MANUAL: rdData_r <= 16'(manual_r);
        `ECIO_IDX_SETPOINT: rdData_r <= setpoint_r;
        `ECIO_IDX_OUT_FUNC: rdData_r <= 16'(outFunc_r);
        `ECIO_IDX_OUT_CHAN: rdData_r <= 16'(outChan_r);
        `ECIO_IDX_OUT_MODE: rdData_r <= 16'(outMode_r);
        `ECIO_IDX_HYST: rdData_r <= 16'(hyst_r);
        `ECIO_IDX_LATCH: rdData_r <= 16'(latch_r);
        `ECIO_IDX_ALM_DELAY: rdData_r <= 16'(almDelay_r);
        default: ;
      endcase
    end
  end

  // outputs straight from flops
  assign regRdData = rdData_r;
  assign regWrReject = wrReject_r;
  assign logicResult = result_r;
  assign outDrive = outDrive_r;
  assign alarmSetpoint = setpoint_r;
  assign outFunction = outFunc_r;
  assign outChannel = outChan_r;
  assign outMode = outMode_r;
  assign alarmHyst = hyst_r;
  assign alarmLatch = latch_r;
  assign alarmDelay = almDelay_r;

  // checks
  sequence s_typeBad;
    regWrEn && regAddr <= 5'h03 && regWrData > `ECIO_TYPE_MAX;
  endsequence
  property p_typeRefused;
    @(posedge core_clk) disable iff (!nrst)
    s_typeBad |=> regWrReject && $stable(inType_r[0]);
  endproperty
  a_typeRefused: assert property (p_typeRefused) else $error("bad type stored");

  property p_chanRange;
    @(posedge core_clk) disable iff (!nrst)
    inChan_r[1] >= 7'h01 && inChan_r[1] <= 7'h50;
  endproperty
  a_chanRange: assert property (p_chanRange) else $error("channel out of range");

  property p_invertMon;
    @(posedge core_clk) disable iff (!nrst)
    regAddr == `ECIO_IDX_LOGIC_MON |=> regRdData[3:0] == $past(logicIn);
  endproperty
  a_invertMon: assert property (p_invertMon) else $error("logic monitor wrong");

  property p_combNor;
    @(posedge core_clk) disable iff (!nrst)
    combine_r == ecio_pkg::COMB_NOR |-> rawResult == (logicIn == 4'h0);
  endproperty
  a_combNor: assert property (p_combNor) else $error("nor combine wrong");

  // count must start from zero, otherwise an older run of samples shortens the wait
  sequence s_holdThree;
    (inDelay_r == 8'h03 && rawResult != result_r && stableCnt_r == 8'h00)
      ##1 (inDelay_r == 8'h03 && rawResult != result_r)[*2];
  endsequence
  property p_delayThree;
    @(posedge core_clk) disable iff (!nrst)
    s_holdThree |=> result_r == $past(rawResult);
  endproperty
  a_delayThree: assert property (p_delayThree) else $error("delay not honoured");

  property p_noEarly;
    @(posedge core_clk) disable iff (!nrst)
    inDelay_r == 8'h03 && stableCnt_r == 8'h00 && rawResult != result_r |=> $stable(result_r);
  endproperty
  a_noEarly: assert property (p_noEarly) else $error("result changed early");

  property p_outState;
    @(posedge core_clk) disable iff (!nrst)
    regAddr == `ECIO_IDX_OUT_STATE |=> regRdData[15:8] == 8'h00;
  endproperty
  a_outState: assert property (p_outState) else $error("status upper bits set");

  property p_hystRange;
    @(posedge core_clk) disable iff (!nrst)
    regWrEn && regAddr == `ECIO_IDX_HYST && regWrData > `ECIO_HYST_MAX |=> $stable(hyst_r);
  endproperty
  a_hystRange: assert property (p_hystRange) else $error("hysteresis overrun");

  property p_setpointKept;
    @(posedge core_clk) disable iff (!nrst)
    regWrEn && regAddr == `ECIO_IDX_SETPOINT && $signed(regWrData) > alarmLimHi
      |=> $stable(setpoint_r) && regWrReject;
  endproperty
  a_setpointKept: assert property (p_setpointKept) else $error("setpoint over limit");

  // lower limit side of the setpoint window
  property p_setpointLow;
    @(posedge core_clk) disable iff (!nrst)
    regWrEn && regAddr == `ECIO_IDX_SETPOINT && $signed(regWrData) < alarmLimLo
      |=> $stable(setpoint_r) && regWrReject;
  endproperty
  a_setpointLow: assert property (p_setpointLow) else $error("setpoint under limit");

  // every refused write raises the flag in the next cycle
  property p_rejectPulse;
    @(posedge core_clk) disable iff (!nrst)
    regWrEn && !wrOk |=> regWrReject;
  endproperty
  a_rejectPulse: assert property (p_rejectPulse) else $error("refusal not flagged");

  // zero delay: result follows the raw value at the next edge
  property p_zeroDelay;
    @(posedge core_clk) disable iff (!nrst)
    inDelay_r == 8'h00 && rawResult != result_r |=> result_r == $past(rawResult);
  endproperty
  a_zeroDelay: assert property (p_zeroDelay) else $error("zero delay lagged");

  // drive word is the manual bits merged with the function request, one cycle late
  property p_outDrive;
    @(posedge core_clk) disable iff (!nrst)
    1'b1 |=> outDrive_r == ($past(manual_r) | $past(eventOutReq));
  endproperty
  a_outDrive: assert property (p_outDrive) else $error("drive word wrong");

  // logic monitor carries only four inputs and the result
  property p_logicMonHigh;
    @(posedge core_clk) disable iff (!nrst)
    regAddr == `ECIO_IDX_LOGIC_MON |=> regRdData[15:5] == 11'h000;
  endproperty
  a_logicMonHigh: assert property (p_logicMonHigh) else $error("monitor upper bits");

endmodule

// ---- dv/tb_top.sv ----
// self-checking bench for the event contact i/o settings bank.
// assumes ecio_top with default parameters and ecio_defs.svh on the include path.
`timescale 1ns/100ps
`include "ecio_defs.svh"

module tb_top;
  typedef struct {
    logic [4:0] a;
    logic [15:0] d;
    logic rj;
    logic [15:0] q;
  } ecio_row_s;
  // design ports
  logic core_clk = 1'b0;
  logic nrst;
  logic [4:0] regAddr = 5'h00;
  logic regWrEn = 1'b0;
  logic [15:0] regWrData = 16'h0000;
  logic [7:0] contactPin = 8'h00;
  logic [71:0] extEvent = '0;
  logic [7:0] eventOutReq = 8'h00;
  logic signed [15:0] alarmLimLo = 16'hff9c;
  logic signed [15:0] alarmLimHi = 16'h0064;
  logic [15:0] regRdData, alarmSetpoint;
  logic regWrReject, logicResult, alarmLatch, seen, expL;
  logic [7:0] outDrive, alarmDelay;
  logic [4:0] outFunction;
  logic [5:0] outChannel, outMode;
  logic [9:0] alarmHyst;
  logic [3:0] pat;
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;
  // register values expected right after reset, by index
  logic [15:0] rstQ [25] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0001,
    16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0000,
    16'h000a, 16'h0000, 16'h0000};
  // write, reject flag, readback; refused rows on writable indices keep the last accepted value
  ecio_row_s rows [36] = '{
    '{5'h00, 16'h0010, 1'b0, 16'h0010}, '{5'h01, 16'h0011, 1'b1, 16'h0000},
    '{5'h02, 16'h001e, 1'b1, 16'h0000}, '{5'h03, 16'h001f, 1'b1, 16'h0000},
    '{5'h04, 16'h0050, 1'b0, 16'h0050}, '{5'h05, 16'h0000, 1'b1, 16'h0001},
    '{5'h06, 16'h0051, 1'b1, 16'h0001}, '{5'h08, 16'h0001, 1'b0, 16'h0001},
    '{5'h09, 16'h0002, 1'b1, 16'h0000}, '{5'h0c, 16'h0003, 1'b0, 16'h0003},
    '{5'h0c, 16'h0004, 1'b1, 16'h0003}, '{5'h0d, 16'h00ff, 1'b0, 16'h00ff},
    '{5'h0d, 16'h0100, 1'b1, 16'h00ff}, '{5'h0e, 16'h0001, 1'b1, 16'h0000},
    '{5'h19, 16'h0001, 1'b1, 16'h0000}, '{5'h11, 16'h0100, 1'b1, 16'h0000},
    '{5'h11, 16'h00ff, 1'b0, 16'h00ff}, '{5'h10, 16'h0000, 1'b1, 16'h00ff},
    '{5'h12, 16'h0065, 1'b1, 16'h0000}, '{5'h12, 16'hff9b, 1'b1, 16'h0000},
    '{5'h12, 16'h0064, 1'b0, 16'h0064}, '{5'h12, 16'hff9c, 1'b0, 16'hff9c},
    '{5'h13, 16'h001f, 1'b1, 16'h0000}, '{5'h13, 16'h001e, 1'b0, 16'h001e},
    '{5'h14, 16'h0000, 1'b1, 16'h0001}, '{5'h14, 16'h0029, 1'b1, 16'h0001},
    '{5'h14, 16'h0028, 1'b0, 16'h0028}, '{5'h15, 16'h0029, 1'b1, 16'h0000},
    '{5'h15, 16'h0028, 1'b0, 16'h0028}, '{5'h16, 16'h03e9, 1'b1, 16'h000a},
    '{5'h16, 16'h03e8, 1'b0, 16'h03e8}, '{5'h17, 16'h0002, 1'b1, 16'h0000},
    '{5'h17, 16'h0001, 1'b0, 16'h0001}, '{5'h18, 16'h0100, 1'b1, 16'h0000},
    '{5'h18, 16'h00ff, 1'b0, 16'h00ff}, '{5'h0f, 16'h0000, 1'b1, 16'h0001}};

  ecio_top ecio_top_inst (.core_clk(core_clk), .nrst(nrst), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdData(regRdData),
    .regWrReject(regWrReject), .contactPin(contactPin), .extEvent(extEvent),
    .eventOutReq(eventOutReq), .alarmLimLo(alarmLimLo), .alarmLimHi(alarmLimHi),
    .logicResult(logicResult), .outDrive(outDrive), .alarmSetpoint(alarmSetpoint),
    .outFunction(outFunction), .outChannel(outChannel), .outMode(outMode),
    .alarmHyst(alarmHyst), .alarmLatch(alarmLatch), .alarmDelay(alarmDelay));

  // 50 MHz clock
  initial begin
    forever #10 core_clk = ~core_clk;
  end

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask

  // inputs move 1 ns after the rising edge
  task automatic step();
    @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic rj);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    step();
    regWrEn = 1'b0;
    chk({15'h0000, regWrReject}, {15'h0000, rj});
    // strobe low across one edge so a following write never re-raises it at once
    step();
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] q);
    regAddr = a;
    step();
    chk(regRdData, q);
  endtask

  // reset values at the ports and in every register
  task automatic do_reset();
    nrst = 1'b0;
    repeat (3) step();
    chk({14'h0000, logicResult, regWrReject}, 16'h0000);
    chk({8'h00, outDrive}, 16'h0000);
    chk({10'h000, outChannel}, 16'h0001);
    chk({6'h00, alarmHyst}, 16'h000a);
    nrst = 1'b1;
    for (int i = 0; i < 25; i++) rd(5'(i), rstQ[i]);
  endtask

  // long-or-short contact pulse on input 1, noting whether the result rose
  task automatic pulse(input int n, input logic exp);
    seen = 1'b0;
    contactPin[0] = 1'b1;
    repeat (n) begin
      step();
      seen |= logicResult;
    end
    contactPin[0] = 1'b0;
    repeat (20) begin
      step();
      seen |= logicResult;
    end
    chk({15'h0000, seen}, {15'h0000, exp});
  endtask

  initial begin
    do_reset();
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, rows[i].rj);
      rd(rows[i].a, rows[i].q);
    end
    chk({11'h000, outFunction}, 16'h001e);
    chk({2'b00, outMode, 2'b00, outChannel}, 16'h2828);
    chk({6'h00, alarmHyst}, 16'h03e8);
    chk({7'h00, alarmLatch, alarmDelay}, 16'h01ff);
    chk(alarmSetpoint, 16'hff9c);
    // mid-run reset, then back-to-back manual writes with a same-cycle read
    do_reset();
    regAddr = 5'h11;
    regWrData = 16'h000a;
    regWrEn = 1'b1;
    step();
    regWrData = 16'h0005;
    step();
    regWrEn = 1'b0;
    chk(regRdData, 16'h000a);
    eventOutReq = 8'h30;
    regAddr = 5'h10;
    repeat (2) step();
    chk(regRdData, 16'h0035);
    chk({8'h00, outDrive}, 16'h0035);
    eventOutReq = 8'h00;
    // all four logic inputs on contacts 1..4, no delay
    for (int k = 0; k < 4; k++) begin
      wr(5'(k), 16'h0001, 1'b0);
      wr(5'(k + 4), 16'(k + 1), 1'b0);
    end
    wr(5'h0d, 16'h0000, 1'b0);
    for (int f = 0; f < 4; f++) begin
      wr(5'h0c, 16'(f), 1'b0);
      for (int j = 0; j < 3; j++) begin
        pat = (j == 0) ? 4'hf : ((j == 1) ? 4'h5 : 4'h0);
        contactPin = 8'ha0 | {4'h0, pat};
        repeat (10) step();
        expL = (f[1] ? |pat : &pat) ^ f[0];
        chk({15'h0000, logicResult}, {15'h0000, expL});
        rd(5'h0f, {11'h000, expL, pat});
        rd(5'h0e, {8'h00, contactPin});
      end
    end
    // inversion of input 1 under AND with contacts 1..4 on
    wr(5'h0c, 16'h0000, 1'b0);
    wr(5'h08, 16'h0001, 1'b0);
    contactPin = 8'h0f;
    repeat (10) step();
    rd(5'h0f, 16'h000e);
    // input 1 taken from channel 80
    wr(5'h08, 16'h0000, 1'b0);
    wr(5'h04, 16'h0050, 1'b0);
    extEvent[71] = 1'b1;
    repeat (10) step();
    chk({15'h0000, logicResult}, 16'h0001);
    extEvent[71] = 1'b0;
    repeat (10) step();
    chk({15'h0000, logicResult}, 16'h0000);
    // delay filter: OR of input 1 alone
    contactPin = 8'h00;
    for (int k = 1; k < 4; k++) wr(5'(k), 16'h0000, 1'b0);
    wr(5'h04, 16'h0001, 1'b0);
    wr(5'h0c, 16'h0002, 1'b0);
    wr(5'h0d, 16'h0003, 1'b0);
    pulse(2, 1'b0);
    pulse(3, 1'b1);
    wr(5'h0d, 16'h0000, 1'b0);
    pulse(3, 1'b1);
    report_and_stop();
  end
endmodule
